// >>> common/mpm_pkg.sv
// Constants, offsets and types shared by the motor protection monitor
package mpm_pkg;
	localparam int unsigned CLK_HZ = 50_000_000;
	localparam int unsigned TICK_MS = 100;
	localparam int unsigned TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
	localparam int unsigned ONE_MIN_MS = 60_000;
	localparam int unsigned ONE_MIN_TICKS = ONE_MIN_MS / TICK_MS;
	localparam int AW = 8;
	localparam int DW = 32;
	localparam int IW = 16;
	// Register byte offsets
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_VOLT = 8'h04;
	localparam logic [7:0] OFS_SAVE = 8'h08;
	localparam logic [7:0] OFS_RATED = 8'h0c;
	localparam logic [7:0] OFS_MISS = 8'h10;
	localparam logic [7:0] OFS_THERM = 8'h14;
	localparam logic [7:0] OFS_OLW = 8'h18;
	localparam logic [7:0] OFS_OLT = 8'h1c;
	localparam logic [7:0] OFS_STAT = 8'h20;
	localparam logic [7:0] OFS_ENERGY = 8'h24;
	localparam logic [7:0] OFS_TEMP = 8'h28;
	localparam logic [7:0] OFS_VCMD = 8'h2c;
	// Control bit positions
	localparam int CB_MISS_EN = 2;
	localparam int CB_THERM_EN = 3;
	localparam int CB_FORCED = 4;
	localparam int CB_OLT_EN = 5;
	localparam int CB_AUX_OL = 6;
	// Reset values
	localparam logic [6:0] RST_CTRL = 7'h4c;
	localparam logic [6:0] RST_MISS_LVL = 7'h05;
	localparam logic [6:0] RST_MISS_TIME = 7'h1e;
	localparam logic [7:0] RST_TH_MIN = 8'h96;
	localparam logic [7:0] RST_TH_CONT = 8'h64;
	localparam logic [7:0] RST_OLW_LVL = 8'h6e;
	localparam logic [9:0] RST_OLW_TIME = 10'h064;
	localparam logic [7:0] RST_OLT_LVL = 8'h78;
	localparam logic [9:0] RST_OLT_DELAY = 10'h258;
	localparam logic [15:0] RST_RATED = 16'h0064;
	// Limits and derating figures (frequency in 0.1 Hz, derate in 0.1 %)
	localparam logic [4:0] SAVE_MAX = 5'h1e;
	localparam logic [6:0] MISS_MIN = 7'h05;
	localparam logic [6:0] MISS_MAX = 7'h64;
	localparam logic [7:0] AUTO_SAVE_PCT = 8'h14;
	localparam logic [26:0] ENERGY_MAX = 27'h5f5e0ff;
	localparam logic [15:0] DER_KNEE = 16'h00c8;
	localparam logic [15:0] DER_HI_OFS = 16'h039d;
	localparam logic [15:0] DER_LO_OFS = 16'h028a;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	typedef enum logic [1:0] {
		SAVE_NONE = 2'h0,
		SAVE_MANUAL = 2'h1,
		SAVE_AUTO = 2'h2
	} mpm_save_e;
	typedef enum logic [2:0] {
		OL_IDLE = 3'h1,
		OL_ON = 3'h2,
		OL_HOLD = 3'h4
	} mpm_ol_e;
endpackage : mpm_pkg

// >>> verilog/mpm_monitor.sv
// Motor protection monitor with AXI4-Lite register access
// What this block does
// (RULE_01) Save select: 0 off, 1 manual, 2 auto
// (RULE_02) Manual save 0 to 30 percent
// (RULE_03) Voltage reduction only at steady speed
// (RULE_04) Hold motor voltage, clamp to input voltage
// (RULE_05) Energy accumulates to ceiling, cleared only by reset
// (RULE_06) Low current too long gives diagnostic trip
// (RULE_07) Thermal overheat disables output, flags trip
// (RULE_08) One-minute level trips after one minute
// (RULE_09) Continuous level set below one-minute level; not checked on write, any pair is stored
// (RULE_10) Self-cool above 20 Hz: 0.125f+92.5
// (RULE_11) Self-cool up to 20 Hz: 1.5f+65
// (RULE_12) Forced-cool uses continuous level unchanged
// (RULE_13) Squared current integrated at all times
// (RULE_14) Alarm after warning level held warning time
// (RULE_15) Alarm held one more warning time
// (RULE_16) Alarm never stops; aux contact if selected
// (RULE_17) Enabled overload trip after delay above level
// (RULE_18) Levels are percent of rated current
// (RULE_19) Switch temperature readable
// (RULE_20) Motor temperature from sensor terminal readable
// (RULE_21) Missing-motor level 5-100, time 0.5-10 s
// (RULE_22) 0.1 s timers clear when condition ends
`timescale 1ns/1ns
module mpm_monitor #(
	parameter int unsigned TICK_CYCLES = mpm_pkg::TICK_CYCLES
) (
	// Clock and reset
	input wire logic clk_in,
	input wire logic reset_in,
	// AXI4-Lite slave
	input wire logic [mpm_pkg::AW-1:0] s_axi_awaddr_in,
	input wire logic s_axi_awvalid_in,
	output logic s_axi_awready_out,
	input wire logic [mpm_pkg::DW-1:0] s_axi_wdata_in,
	input wire logic [3:0] s_axi_wstrb_in,
	input wire logic s_axi_wvalid_in,
	output logic s_axi_wready_out,
	output logic [1:0] s_axi_bresp_out,
	output logic s_axi_bvalid_out,
	input wire logic s_axi_bready_in,
	input wire logic [mpm_pkg::AW-1:0] s_axi_araddr_in,
	input wire logic s_axi_arvalid_in,
	output logic s_axi_arready_out,
	output logic [mpm_pkg::DW-1:0] s_axi_rdata_out,
	output logic [1:0] s_axi_rresp_out,
	output logic s_axi_rvalid_out,
	input wire logic s_axi_rready_in,
	// Drive measurements
	input wire logic [mpm_pkg::IW-1:0] current_in,
	input wire logic [15:0] frequency_in,
	input wire logic [15:0] input_voltage_in,
	input wire logic at_speed_in,
	input wire logic energy_tick_in,
	input wire logic [7:0] switch_temp_in,
	input wire logic [7:0] thermal_sensor_terminal_in,
	// Drive and alarm outputs
	output logic [15:0] voltage_cmd_out,
	output logic output_shutdown_out,
	output logic overload_alarm_out,
	output logic aux_contact_output_out
);
	import mpm_pkg::*;

	logic [6:0] ctrl, next_ctrl;
	logic [15:0] motor_voltage_setting, next_motor_voltage_setting;
	logic [4:0] manual_save_percent, next_manual_save_percent;
	logic [15:0] rated_motor_current, next_rated_motor_current;
	logic [6:0] missing_motor_level, next_missing_motor_level;
	logic [6:0] missing_motor_time, next_missing_motor_time;
	logic [7:0] thermal_one_minute_level, next_thermal_one_minute_level;
	logic [7:0] thermal_continuous_level, next_thermal_continuous_level;
	logic [7:0] overload_warning_level, next_overload_warning_level;
	logic [9:0] overload_warning_time, next_overload_warning_time;
	logic [7:0] overload_trip_level, next_overload_trip_level;
	logic [9:0] overload_trip_delay, next_overload_trip_delay;
	logic aw_held, next_aw_held, w_held, next_w_held;
	logic [AW-1:0] waddr, next_waddr;
	logic [DW-1:0] wdata, next_wdata;
	logic [3:0] wstrb, next_wstrb;
	logic bvalid, next_bvalid, rvalid, next_rvalid;
	logic [1:0] bresp, next_bresp, rresp, next_rresp;
	logic [DW-1:0] rdata, next_rdata;
	logic wr_fire;
	logic [DW-1:0] wr_word;
	logic [2:0] trip_clr;
	logic [31:0] tick_cnt, next_tick_cnt;
	logic tick;
	logic [6:0] mm_cnt, next_mm_cnt;
	logic [9:0] olw_cnt, next_olw_cnt, olt_cnt, next_olt_cnt;
	mpm_ol_e ol_state, next_ol_state;
	logic [2:0] trip_flags, next_trip_flags;
	logic [26:0] energy_accumulator, next_energy_accumulator;
	logic [7:0] switch_temperature_monitor, motor_temperature_monitor;
	logic [15:0] vcmd, next_vcmd, vbase;
	logic [63:0] heat, next_heat, heat_limit, x_sq, c_sq;
	logic [31:0] x_cur, c_cur, m_cur;
	logic [15:0] derate;
	logic [31:0] cont_lvl;
	logic mm_below, ol_ge, olt_above;

	// Current against a percentage of the rated current
	function automatic logic pct_ge(input logic [15:0] cur, input logic [7:0] lvl, input logic [15:0] rated);
		pct_ge = (32'(cur) * 32'd100) >= (32'(lvl) * 32'(rated));
	endfunction : pct_ge

	function automatic logic [DW-1:0] merge(input logic [DW-1:0] old, input logic [DW-1:0] val, input logic [3:0] strb);
		merge = old;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				merge[8*b +: 8] = val[8*b +: 8];
			end
		end
	endfunction : merge

	function automatic logic [6:0] miss_clamp(input logic [6:0] v);
		miss_clamp = (v < MISS_MIN) ? MISS_MIN : ((v > MISS_MAX) ? MISS_MAX : v);
	endfunction : miss_clamp

	function automatic logic [DW-1:0] reg_word(input logic [AW-1:0] a);
		if (a == OFS_CTRL) begin
			reg_word = {25'h0, ctrl};
		end else if (a == OFS_VOLT) begin
			reg_word = {16'h0, motor_voltage_setting};
		end else if (a == OFS_SAVE) begin
			reg_word = {27'h0, manual_save_percent};
		end else if (a == OFS_RATED) begin
			reg_word = {16'h0, rated_motor_current};
		end else if (a == OFS_MISS) begin
			reg_word = {17'h0, missing_motor_time, 1'b0, missing_motor_level};
		end else if (a == OFS_THERM) begin
			reg_word = {16'h0, thermal_continuous_level, thermal_one_minute_level};
		end else if (a == OFS_OLW) begin
			reg_word = {6'h0, overload_warning_time, 8'h0, overload_warning_level};
		end else if (a == OFS_OLT) begin
			reg_word = {6'h0, overload_trip_delay, 8'h0, overload_trip_level};
		end else if (a == OFS_STAT) begin
			reg_word = {28'h0, overload_alarm_out, trip_flags};
		end else if (a == OFS_ENERGY) begin
			reg_word = {5'h0, energy_accumulator}; // [RULE_05]
		end else if (a == OFS_TEMP) begin
			reg_word = {16'h0, motor_temperature_monitor, switch_temperature_monitor}; // [RULE_19] [RULE_20]
		end else if (a == OFS_VCMD) begin
			reg_word = {16'h0, vcmd};
		end else begin
			reg_word = 32'h0;
		end
	endfunction : reg_word

	function automatic logic mapped(input logic [AW-1:0] a);
		mapped = (a[1:0] == 2'h0) && (a <= OFS_VCMD);
	endfunction : mapped

	// Bus handshakes
	assign s_axi_awready_out = !aw_held && !bvalid;
	assign s_axi_wready_out = !w_held && !bvalid;
	assign s_axi_arready_out = !rvalid;
	assign s_axi_bvalid_out = bvalid;
	assign s_axi_bresp_out = bresp;
	assign s_axi_rvalid_out = rvalid;
	assign s_axi_rresp_out = rresp;
	assign s_axi_rdata_out = rdata;
	assign wr_fire = aw_held && w_held && !bvalid;
	// A process, not an assign: reg_word reads the registers, which an assign would not wake on
	always_comb begin
		wr_word = merge(reg_word(waddr), wdata, wstrb);
	end
	assign trip_clr = (wr_fire && waddr == OFS_STAT) ? wr_word[2:0] : 3'h0;

	always_comb begin
		next_aw_held = aw_held;
		next_w_held = w_held;
		next_waddr = waddr;
		next_wdata = wdata;
		next_wstrb = wstrb;
		next_bvalid = bvalid;
		next_bresp = bresp;
		next_rvalid = rvalid;
		next_rresp = rresp;
		next_rdata = rdata;
		if (s_axi_awvalid_in && s_axi_awready_out) begin
			next_aw_held = 1'b1;
			next_waddr = s_axi_awaddr_in;
		end
		if (s_axi_wvalid_in && s_axi_wready_out) begin
			next_w_held = 1'b1;
			next_wdata = s_axi_wdata_in;
			next_wstrb = s_axi_wstrb_in;
		end
		if (wr_fire) begin
			next_aw_held = 1'b0;
			next_w_held = 1'b0;
			next_bvalid = 1'b1;
			next_bresp = mapped(waddr) ? RESP_OKAY : RESP_SLVERR;
		end else if (bvalid && s_axi_bready_in) begin
			next_bvalid = 1'b0;
		end
		if (s_axi_arvalid_in && s_axi_arready_out) begin
			next_rvalid = 1'b1;
			next_rdata = reg_word(s_axi_araddr_in);
			next_rresp = mapped(s_axi_araddr_in) ? RESP_OKAY : RESP_SLVERR;
		end else if (rvalid && s_axi_rready_in) begin
			next_rvalid = 1'b0;
		end
	end

	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			waddr <= '0;
			wdata <= '0;
			wstrb <= '0;
			bvalid <= 1'b0;
			bresp <= RESP_OKAY;
			rvalid <= 1'b0;
			rresp <= RESP_OKAY;
			rdata <= '0;
		end else begin
			aw_held <= next_aw_held;
			w_held <= next_w_held;
			waddr <= next_waddr;
			wdata <= next_wdata;
			wstrb <= next_wstrb;
			bvalid <= next_bvalid;
			bresp <= next_bresp;
			rvalid <= next_rvalid;
			rresp <= next_rresp;
			rdata <= next_rdata;
		end
	end

	// Configuration registers; range limits applied on write
	always_comb begin
		next_ctrl = ctrl;
		next_motor_voltage_setting = motor_voltage_setting;
		next_manual_save_percent = manual_save_percent;
		next_rated_motor_current = rated_motor_current;
		next_missing_motor_level = missing_motor_level;
		next_missing_motor_time = missing_motor_time;
		next_thermal_one_minute_level = thermal_one_minute_level;
		next_thermal_continuous_level = thermal_continuous_level;
		next_overload_warning_level = overload_warning_level;
		next_overload_warning_time = overload_warning_time;
		next_overload_trip_level = overload_trip_level;
		next_overload_trip_delay = overload_trip_delay;
		if (wr_fire) begin
			if (waddr == OFS_CTRL) begin
				next_ctrl = wr_word[6:0];
			end else if (waddr == OFS_VOLT) begin
				next_motor_voltage_setting = wr_word[15:0];
			end else if (waddr == OFS_SAVE) begin
				// Clamp on the whole word so that large values do not wrap into range
				next_manual_save_percent = (wr_word > 32'(SAVE_MAX)) ? SAVE_MAX : wr_word[4:0]; // [RULE_02]
			end else if (waddr == OFS_RATED) begin
				next_rated_motor_current = wr_word[15:0];
			end else if (waddr == OFS_MISS) begin
				next_missing_motor_level = miss_clamp(wr_word[6:0]); // [RULE_21]
				next_missing_motor_time = miss_clamp(wr_word[14:8]); // [RULE_21]
			end else if (waddr == OFS_THERM) begin
				next_thermal_one_minute_level = wr_word[7:0];
				next_thermal_continuous_level = wr_word[15:8];
			end else if (waddr == OFS_OLW) begin
				next_overload_warning_level = wr_word[7:0];
				next_overload_warning_time = wr_word[25:16];
			end else if (waddr == OFS_OLT) begin
				next_overload_trip_level = wr_word[7:0];
				next_overload_trip_delay = wr_word[25:16];
			end
		end
	end

	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			ctrl <= RST_CTRL;
			motor_voltage_setting <= '0;
			manual_save_percent <= '0;
			rated_motor_current <= RST_RATED;
			missing_motor_level <= RST_MISS_LVL;
			missing_motor_time <= RST_MISS_TIME;
			thermal_one_minute_level <= RST_TH_MIN;
			thermal_continuous_level <= RST_TH_CONT;
			overload_warning_level <= RST_OLW_LVL;
			overload_warning_time <= RST_OLW_TIME;
			overload_trip_level <= RST_OLT_LVL;
			overload_trip_delay <= RST_OLT_DELAY;
		end else begin
			ctrl <= next_ctrl;
			motor_voltage_setting <= next_motor_voltage_setting;
			manual_save_percent <= next_manual_save_percent;
			rated_motor_current <= next_rated_motor_current;
			missing_motor_level <= next_missing_motor_level;
			missing_motor_time <= next_missing_motor_time;
			thermal_one_minute_level <= next_thermal_one_minute_level;
			thermal_continuous_level <= next_thermal_continuous_level;
			overload_warning_level <= next_overload_warning_level;
			overload_warning_time <= next_overload_warning_time;
			overload_trip_level <= next_overload_trip_level;
			overload_trip_delay <= next_overload_trip_delay;
		end
	end

	// Thermal model terms: levels and derate in 0.1 percent, currents scaled by 1000
	always_comb begin
		if (frequency_in > DER_KNEE) begin
			derate = 16'(frequency_in / 16'd8) + DER_HI_OFS; // [RULE_10]
		end else begin
			derate = 16'((17'(frequency_in) * 17'd3) >> 1) + DER_LO_OFS; // [RULE_11]
		end
		if (ctrl[CB_FORCED]) begin
			cont_lvl = 32'(thermal_continuous_level) * 32'd10; // [RULE_12]
		end else begin
			cont_lvl = (32'(thermal_continuous_level) * 32'(derate)) / 32'd100;
		end
		x_cur = 32'(current_in) * 32'd1000; // [RULE_18]
		c_cur = cont_lvl * 32'(rated_motor_current);
		m_cur = 32'(thermal_one_minute_level) * 32'(rated_motor_current) * 32'd10;
		x_sq = 64'(x_cur) * 64'(x_cur);
		c_sq = 64'(c_cur) * 64'(c_cur);
		heat_limit = (m_cur > c_cur) ? (64'(m_cur) * 64'(m_cur) - c_sq) * 64'(ONE_MIN_TICKS) : 64'h0; // [RULE_08]
	end

	assign mm_below = !pct_ge(current_in, {1'b0, missing_motor_level}, rated_motor_current);
	assign ol_ge = pct_ge(current_in, overload_warning_level, rated_motor_current);
	assign olt_above = !pct_ge(current_in, overload_trip_level, rated_motor_current)
		? 1'b0 : (32'(current_in) * 32'd100) != (32'(overload_trip_level) * 32'(rated_motor_current));
	assign tick = (tick_cnt >= TICK_CYCLES - 1);

	// Protection timers, alarm sequence and trip flags
	always_comb begin
		next_tick_cnt = tick ? 32'h0 : tick_cnt + 32'h1; // [RULE_22]
		next_mm_cnt = mm_cnt;
		next_olw_cnt = olw_cnt;
		next_olt_cnt = olt_cnt;
		next_ol_state = ol_state;
		next_heat = heat;
		next_trip_flags = trip_flags & ~trip_clr;
		next_energy_accumulator = energy_accumulator;
		if (!(ctrl[CB_MISS_EN] && mm_below)) begin
			next_mm_cnt = 7'h0; // [RULE_22]
		end else if (tick && mm_cnt != 7'h7f) begin
			next_mm_cnt = mm_cnt + 7'h1;
		end
		if (ctrl[CB_MISS_EN] && mm_below && mm_cnt > missing_motor_time) begin
			next_trip_flags[0] = 1'b1; // [RULE_06]
		end
		if (tick) begin
			if (x_sq >= c_sq) begin
				next_heat = (heat + (x_sq - c_sq) > heat_limit) ? heat_limit : heat + (x_sq - c_sq); // [RULE_13]
			end else begin
				next_heat = (heat > c_sq - x_sq) ? heat - (c_sq - x_sq) : 64'h0; // [RULE_13]
			end
		end
		if (ctrl[CB_THERM_EN] && heat_limit != 64'h0 && heat >= heat_limit) begin
			next_trip_flags[1] = 1'b1; // [RULE_07]
		end
		if (!(ctrl[CB_OLT_EN] && olt_above)) begin
			next_olt_cnt = 10'h0; // [RULE_22]
		end else if (tick && olt_cnt != 10'h3ff) begin
			next_olt_cnt = olt_cnt + 10'h1;
		end
		if (ctrl[CB_OLT_EN] && olt_above && olt_cnt >= overload_trip_delay) begin
			next_trip_flags[2] = 1'b1; // [RULE_17]
		end
		case (ol_state)
			OL_IDLE: begin
				if (!ol_ge) begin
					next_olw_cnt = 10'h0; // [RULE_22]
				end else if (olw_cnt >= overload_warning_time) begin
					next_ol_state = OL_ON; // [RULE_14]
					next_olw_cnt = 10'h0;
				end else if (tick) begin
					next_olw_cnt = olw_cnt + 10'h1;
				end
			end
			OL_ON: begin
				if (!ol_ge) begin
					next_ol_state = OL_HOLD; // [RULE_15]
				end
			end
			OL_HOLD: begin
				if (ol_ge) begin
					next_ol_state = OL_ON;
					next_olw_cnt = 10'h0;
				end else if (olw_cnt >= overload_warning_time) begin
					next_ol_state = OL_IDLE; // [RULE_15]
					next_olw_cnt = 10'h0;
				end else if (tick) begin
					next_olw_cnt = olw_cnt + 10'h1;
				end
			end
			default: begin
				next_ol_state = OL_IDLE;
				next_olw_cnt = 10'h0;
			end
		endcase
		if (energy_tick_in && energy_accumulator < ENERGY_MAX) begin
			next_energy_accumulator = energy_accumulator + 27'h1; // [RULE_05]
		end
	end

	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			tick_cnt <= '0;
			mm_cnt <= '0;
			olw_cnt <= '0;
			olt_cnt <= '0;
			ol_state <= OL_IDLE;
			heat <= '0;
			trip_flags <= '0;
			energy_accumulator <= '0;
		end else begin
			tick_cnt <= next_tick_cnt;
			mm_cnt <= next_mm_cnt;
			olw_cnt <= next_olw_cnt;
			olt_cnt <= next_olt_cnt;
			ol_state <= next_ol_state;
			heat <= next_heat;
			trip_flags <= next_trip_flags;
			energy_accumulator <= next_energy_accumulator;
		end
	end

	// Output voltage and monitor values
	always_comb begin
		vbase = (input_voltage_in < motor_voltage_setting) ? input_voltage_in : motor_voltage_setting; // [RULE_04]
		next_vcmd = vbase;
		if (at_speed_in) begin // [RULE_03]
			case (ctrl[1:0])
				SAVE_MANUAL: next_vcmd = 16'((32'(vbase) * (32'd100 - 32'(manual_save_percent))) / 32'd100); // [RULE_01]
				SAVE_AUTO: next_vcmd = 16'((32'(vbase) * (32'd100 - 32'(AUTO_SAVE_PCT))) / 32'd100); // [RULE_01]
				default: next_vcmd = vbase; // [RULE_01]
			endcase
		end
	end

	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			vcmd <= '0;
			switch_temperature_monitor <= '0;
			motor_temperature_monitor <= '0;
		end else begin
			vcmd <= next_vcmd;
			switch_temperature_monitor <= switch_temp_in;
			motor_temperature_monitor <= thermal_sensor_terminal_in;
		end
	end

	assign voltage_cmd_out = vcmd;
	assign output_shutdown_out = |trip_flags; // [RULE_07]
	assign overload_alarm_out = (ol_state != OL_IDLE); // [RULE_16]
	assign aux_contact_output_out = overload_alarm_out && ctrl[CB_AUX_OL]; // [RULE_16]

	default clocking @(posedge clk_in); endclocking
	default disable iff (reset_in);

	chk_save_limit: assert property (manual_save_percent <= SAVE_MAX) // [RULE_02]
		else $error("save percent out of range");
	chk_miss_range: assert property (missing_motor_level >= MISS_MIN && missing_motor_level <= MISS_MAX // [RULE_21]
		&& missing_motor_time >= MISS_MIN && missing_motor_time <= MISS_MAX)
		else $error("missing motor setting out of range");
	chk_no_save_accel: assert property (!at_speed_in |=> vcmd == $past(vbase)) // [RULE_03]
		else $error("voltage reduced while not at speed");
	chk_volt_clamp: assert property (##1 vcmd <= $past(input_voltage_in) // [RULE_04]
		&& vcmd <= $past(motor_voltage_setting))
		else $error("voltage above input or motor setting");
	chk_energy_step: assert property (energy_tick_in && energy_accumulator < ENERGY_MAX // [RULE_05]
		|=> energy_accumulator == $past(energy_accumulator) + 27'h1) else $error("energy not counted");
	chk_energy_cap: assert property (energy_accumulator <= ENERGY_MAX) // [RULE_05]
		else $error("energy above ceiling");
	chk_miss_trip: assert property (ctrl[CB_MISS_EN] && mm_below && mm_cnt > missing_motor_time // [RULE_06]
		|=> trip_flags[0] && output_shutdown_out) else $error("missing motor trip not raised");
	chk_therm_trip: assert property (ctrl[CB_THERM_EN] && heat_limit != 64'h0 && heat >= heat_limit // [RULE_07]
		|=> trip_flags[1]) else $error("thermal trip not raised");
	chk_alarm_hold: assert property (ol_state == OL_ON && !ol_ge // [RULE_15]
		|=> ol_state == OL_HOLD ##1 overload_alarm_out)
		else $error("alarm released without hold");
	chk_aux_gate: assert property (aux_contact_output_out |-> overload_alarm_out && ctrl[CB_AUX_OL]) // [RULE_16]
		else $error("aux contact without selected alarm");
	chk_olt_trip: assert property (ctrl[CB_OLT_EN] && olt_above && olt_cnt >= overload_trip_delay // [RULE_17]
		|=> trip_flags[2]) else $error("overload trip not raised");
	chk_timer_clear: assert property (ol_state == OL_IDLE && !ol_ge |=> olw_cnt == 10'h0) // [RULE_22]
		else $error("warning timer not cleared");
endmodule : mpm_monitor

// >>> dv/mpm_motor_model.sv
// Partner model: motor winding, thermal sensor and energy meter
`timescale 1ns/1ns
module mpm_motor_model (
	// Clock
	input wire logic clk_in,
	// Load and temperature set by the bench
	input wire logic [15:0] load_in,
	input wire logic [7:0] temp_in,
	// Measurements seen by the drive
	output logic [15:0] current_out,
	output logic [7:0] sensor_out,
	output logic energy_tick_out
);
	initial current_out = 16'h0000;
	initial sensor_out = 8'h00;
	initial energy_tick_out = 1'b0;
	// Winding current follows the load and sensor the temperature a clock later
	always @(posedge clk_in) begin
		current_out <= load_in;
		sensor_out <= temp_in;
	end
	// One pulse per 0.1 kWh, spaced so each is seen alone
	task automatic spend(input int n);
		repeat (n) begin
			@(posedge clk_in);
			energy_tick_out <= 1'b1;
			@(posedge clk_in);
			energy_tick_out <= 1'b0;
		end
	endtask : spend
endmodule : mpm_motor_model

// >>> dv/motor_protection_monitor_tb.sv
// Self-checking bench for the motor protection monitor
`timescale 1ns/1ns
module motor_protection_monitor_tb;
	import mpm_pkg::*;
	typedef struct {logic wr; logic [7:0] a; logic [31:0] d; logic [1:0] rs;} mpm_row_s;
	logic clk_in, reset_in = 1, at_speed_in = 1, energy_tick_in, output_shutdown_out;
	logic overload_alarm_out, aux_contact_output_out, s_axi_awready_out, s_axi_wready_out;
	logic s_axi_awvalid_in = 0, s_axi_wvalid_in = 0, s_axi_bready_in = 0, s_axi_bvalid_out;
	logic s_axi_arvalid_in = 0, s_axi_rready_in = 0, s_axi_arready_out, s_axi_rvalid_out;
	logic [7:0] s_axi_awaddr_in = 0, s_axi_araddr_in = 0, switch_temp_in = 8'h2c, thermal_sensor_terminal_in;
	logic [31:0] s_axi_wdata_in = 0, s_axi_rdata_out, d;
	logic [3:0] s_axi_wstrb_in = 4'hf;
	logic [1:0] s_axi_bresp_out, s_axi_rresp_out, r;
	logic [15:0] current_in, frequency_in = 16'h01f4, input_voltage_in = 16'h07d0, voltage_cmd_out, load = 16'h0064;
	int n_fail = 0, n_compared = 0, cycles = 0;
	mpm_row_s rows[18] = '{
		'{0, OFS_CTRL, 32'h4c, 2'h0},
		'{0, OFS_RATED, 32'h64, 2'h0},
		'{0, OFS_MISS, 32'h1e05, 2'h0},
		'{0, OFS_THERM, 32'h6496, 2'h0},
		'{0, OFS_OLW, 32'h0064006e, 2'h0},
		'{0, OFS_OLT, 32'h02580078, 2'h0},
		'{0, 8'h30, 32'h0, 2'h2},
		'{1, 8'h30, 32'h1, 2'h2},
		'{1, OFS_VOLT, 32'h3e8, 2'h0},
		'{1, OFS_SAVE, 32'h32, 2'h0},
		'{0, OFS_SAVE, 32'h1e, 2'h0},
		'{1, OFS_SAVE, 32'h0a, 2'h0},
		'{1, OFS_CTRL, 32'h4d, 2'h0},
		'{0, OFS_VCMD, 32'h384, 2'h0},
		'{1, OFS_CTRL, 32'h4e, 2'h0},
		'{0, OFS_VCMD, 32'h320, 2'h0},
		'{1, OFS_ENERGY, 32'h5, 2'h0},
		'{0, OFS_ENERGY, 32'h0, 2'h0}
	};
	mpm_monitor #(.TICK_CYCLES(10)) mpm_monitor_i (.*);
	mpm_motor_model mpm_motor_model_i (.clk_in(clk_in), .load_in(load), .temp_in(8'h3c),
		.current_out(current_in), .sensor_out(thermal_sensor_terminal_in), .energy_tick_out(energy_tick_in));
	initial begin
		clk_in = 0;
		forever #10 clk_in = ~clk_in;
	end
	task automatic stop_test();
		$display("compared %0d failed %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : stop_test
	always @(posedge clk_in) begin
		cycles++;
		if (cycles == 20000) begin
			n_fail++;
			stop_test();
		end
	end
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
		n_compared++;
		if (s !== e) begin
			n_fail++;
			$display("mismatch %s expected %h seen %h", n, e, s);
		end
	endtask : chk
	task automatic sd(input logic e);
		chk("shutdown", 32'(e), 32'(output_shutdown_out));
	endtask : sd
	task automatic cyc(input int n);
		repeat (n) @(posedge clk_in);
		#1;
	endtask : cyc
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		logic ta = 0, tw = 0, tb = 0;
		s_axi_awaddr_in <= a;
		s_axi_wdata_in <= v;
		s_axi_awvalid_in <= 1;
		s_axi_wvalid_in <= 1;
		s_axi_bready_in <= 1;
		do begin
			@(negedge clk_in);
			ta |= s_axi_awvalid_in & s_axi_awready_out;
			tw |= s_axi_wvalid_in & s_axi_wready_out;
			tb = s_axi_bvalid_out;
			r = s_axi_bresp_out;
			@(posedge clk_in);
			if (ta) s_axi_awvalid_in <= 0;
			if (tw) s_axi_wvalid_in <= 0;
		end while (!tb);
		s_axi_bready_in <= 0;
		#1;
	endtask : wr
	task automatic rd(input logic [7:0] a);
		logic ta = 0, tr = 0;
		s_axi_araddr_in <= a;
		s_axi_arvalid_in <= 1;
		s_axi_rready_in <= 1;
		do begin
			@(negedge clk_in);
			ta |= s_axi_arvalid_in & s_axi_arready_out;
			tr = s_axi_rvalid_out;
			d = s_axi_rdata_out;
			r = s_axi_rresp_out;
			@(posedge clk_in);
			if (ta) s_axi_arvalid_in <= 0;
		end while (!tr);
		s_axi_rready_in <= 0;
		#1;
	endtask : rd
	initial begin
		repeat (10) @(posedge clk_in);
		reset_in <= 0;
		cyc(1);
		foreach (rows[i]) begin
			if (rows[i].wr) wr(rows[i].a, rows[i].d);
			else rd(rows[i].a);
			if (!rows[i].wr) chk("rdata", rows[i].d, d);
			chk("resp", 32'(rows[i].rs), 32'(r));
		end
		$display("test table done");
		wr(OFS_CTRL, 32'h4c);
		input_voltage_in <= 16'h02bc;
		cyc(2);
		chk("vcmd", 32'h2bc, 32'(voltage_cmd_out));
		wr(OFS_CTRL, 32'h4d);
		at_speed_in <= 0;
		cyc(2);
		chk("vcmd", 32'h2bc, 32'(voltage_cmd_out));
		at_speed_in <= 1;
		cyc(2);
		chk("vcmd", 32'h276, 32'(voltage_cmd_out));
		input_voltage_in <= 16'h07d0;
		mpm_motor_model_i.spend(5);
		rd(OFS_ENERGY);
		chk("energy", 32'h5, d);
		rd(OFS_TEMP);
		chk("temp", 32'h3c2c, d);
		$display("test voltage energy done");
		wr(OFS_MISS, 32'h0505);
		load <= 16'h0004;
		cyc(40);
		sd(0);
		cyc(50);
		sd(1);
		load <= 16'h0064;
		wr(OFS_STAT, 32'h1);
		sd(0);
		$display("test missing motor done");
		wr(OFS_OLW, 32'h0003006e);
		load <= 16'h006e;
		cyc(15);
		chk("alarm", 0, 32'(overload_alarm_out));
		cyc(45);
		chk("alarm", 1, 32'(overload_alarm_out));
		chk("aux", 1, 32'(aux_contact_output_out));
		sd(0);
		wr(OFS_CTRL, 32'h0d);
		chk("aux", 0, 32'(aux_contact_output_out));
		load <= 16'h0064;
		cyc(15);
		chk("alarm", 1, 32'(overload_alarm_out));
		cyc(60);
		chk("alarm", 0, 32'(overload_alarm_out));
		$display("test warning done");
		wr(OFS_OLT, 32'h00040078);
		wr(OFS_CTRL, 32'h2d);
		load <= 16'h0078;
		cyc(100);
		sd(0);
		repeat (2) begin
			load <= 16'h0079;
			cyc(30);
			load <= 16'h0064;
			cyc(20);
		end
		sd(0);
		load <= 16'h0079;
		cyc(80);
		sd(1);
		load <= 16'h0064;
		wr(OFS_STAT, 32'h4);
		wr(OFS_CTRL, 32'h19);
		sd(0);
		$display("test overload trip done");
		load <= 16'h0004;
		cyc(300);
		wr(OFS_THERM, 32'h6465);
		load <= 16'h0064;
		cyc(300);
		sd(0);
		load <= 16'h0096;
		cyc(80);
		sd(0);
		cyc(70);
		sd(1);
		$display("test thermal done");
		reset_in <= 1;
		cyc(2);
		reset_in <= 0;
		cyc(1);
		sd(0);
		chk("vcmd", 32'h0, 32'(voltage_cmd_out));
		$display("test reset done");
		stop_test();
	end
endmodule : motor_protection_monitor_tb
